// [dcg_defs.svh]
/*
  Constants of the discharge current and cell heat guard: register
  offsets, field positions, reset values and timebase figures.
  Assumes inclusion by bare name from the design module and the bench.
*/
`ifndef DCG_DEFS_SVH
`define DCG_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------
`define DCG_OFF_CTRL      8'h00
`define DCG_OFF_OC_THR    8'h04
`define DCG_OFF_OC_DLY    8'h08
`define DCG_OFF_L3_THR    8'h0C
`define DCG_OFF_LATCH     8'h10
`define DCG_OFF_LREC      8'h14
`define DCG_OFF_OT_THR    8'h18
`define DCG_OFF_OT_DLY    8'h1C
`define DCG_OFF_CMD       8'h20
`define DCG_OFF_STATUS    8'h24
`define DCG_OFF_TEMP      8'h28

// ----------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------
`define DCG_CTRL_EN_L1    0
`define DCG_CTRL_EN_L2    1
`define DCG_CTRL_EN_L3    2
`define DCG_CTRL_EN_LATCH 3
`define DCG_CTRL_EN_OTC   4
`define DCG_CTRL_EN_OTD   5
`define DCG_CTRL_AUTO     6
`define DCG_CTRL_CUR_REC  7
`define DCG_CTRL_SERIES   8
`define DCG_CTRL_SEL_OTD  9
`define DCG_CTRL_SEL_OTC  10

// ----------------------------------------------------------------
// Alert and fault vector positions
// ----------------------------------------------------------------
`define DCG_P_L1          0
`define DCG_P_L2          1
`define DCG_P_L3          2
`define DCG_P_LATCH       3
`define DCG_P_OTC         4
`define DCG_P_OTD         5

// ----------------------------------------------------------------
// Reset values and command code
// ----------------------------------------------------------------
`define DCG_RST_WORD      32'h0000_0000
`define DCG_CMD_LATCH_REC 16'h009B

// ----------------------------------------------------------------
// Timebase
// ----------------------------------------------------------------
`define DCG_CLK_MHZ       250
`define DCG_FAST_TICK_US  3300
`define DCG_SLOW_TICK_US  1000000
`define DCG_FAST_TICK_CYC (`DCG_FAST_TICK_US * `DCG_CLK_MHZ)
`define DCG_SLOW_TICK_CYC (`DCG_SLOW_TICK_US * `DCG_CLK_MHZ)
`define DCG_L12_DLY_ADD   9'h002

`endif

// [dcg_pkg.sv]
/*
  Types of the discharge current and cell heat guard: the status word
  and the persistence timer channel names.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dcg_pkg;

  // Status word as read back by software
  typedef struct packed {
    logic [7:0] latch_count;
    logic [5:0] rsvd2;
    logic chg_off;
    logic dsg_alarm;
    logic [1:0] rsvd1;
    logic [5:0] fault;
    logic [1:0] rsvd0;
    logic [5:0] alert;
  } dcg_status_t;

  // Persistence timer channels
  typedef enum logic [3:0] {
    TMR_L1 = 4'b0000, TMR_L2 = 4'b0001, TMR_L3 = 4'b0010,
    TMR_OTC = 4'b0011, TMR_OTD = 4'b0100, TMR_OCREC = 4'b0101,
    TMR_LREC = 4'b0110, TMR_OTCREC = 4'b0111, TMR_OTDREC = 4'b1000,
    TMR_DEC = 4'b1001
  } dcg_tmr_t;

endpackage

// [dcg_guard.sv]
/*
  Discharge overcurrent (three levels), repeated-overcurrent latch and
  cell overtemperature (charge and discharge) protection logic.
  Assumes sense, current and temperature samples arrive from logic on
  clk; the load-detect flag arrives from outside and is synchronised.
*/
`timescale 1ns/1ps
`include "dcg_defs.svh"

// What this block does
// R1: Levels one, two alert while sense difference exceeds threshold.
// R2: Level three alert while coulomb current is at or below its threshold.
// R3: Persisting alert trips: alert cleared, level fault status set.
// R4: Any overcurrent level trip raises the discharge-off alarm under autonomous control.
// R5: Each cycle with an overcurrent trip adds one to the latch counter, up to its maximum.
// R6: Current above recovery threshold for recovery time clears the faults.
// R7: All levels normal, counter above zero: decrement once per delay period.
// R8: Latch alert while the latch counter is above zero and no latch fault is set.
// R9: Counter at limit sets latch fault, clears alert, raises alarm under autonomous control.
// R10: Load removed clears latch fault and counter; alarm only if no level faults.
// R11: Current above latch recovery threshold clears latch fault and counter.
// R12: Host command 0x009B clears latch fault and counter.
// R13: Charge overtemperature alert when enabled and at or above threshold.
// R14: Charge overtemperature faults after persisting 0 to 255 seconds.
// R15: Charge fault turns charge switch off when autonomous and selected.
// R16: Charge fault recovers at or below recovery level for recovery time.
// R17: Both temperature checks use the maximum of enabled cell sensors.
// R18: Discharge overtemperature alert when enabled and at or above threshold.
// R19: Discharge overtemperature faults after persisting 0 to 255 seconds.
// R20: Discharge fault turns discharge switch off if autonomous and selected.
// R21: Discharge fault recovers at or below its recovery level for time.
// R22: Levels one and two trip after 3.3 ms ticks times setting plus two.
// R23: Level three trips after 0 to 255 one-second ticks.
// R24: Current recovery needs enable bit, series switches, charge switch on.
// R25: Each delay timer restarts whenever its condition drops.
// R26: Latch counter saturates at zero and at its maximum.
module dcg_guard
  import dcg_pkg::*;
#(
  parameter int NUM_TEMP = 4,
  parameter int FAST_TICK_CYC = `DCG_FAST_TICK_CYC,
  parameter int SLOW_TICK_CYC = `DCG_SLOW_TICK_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic signed [15:0] sense_neg_minus_pos_mv,
  input wire logic signed [15:0] coulomb_counter_current,
  input wire logic signed [7:0] cell_temp [NUM_TEMP],
  input wire logic [NUM_TEMP-1:0] cell_temp_enable,
  input wire logic load_removed,
  input wire logic charge_switch_on,
  output logic discharge_switch_off,
  output logic charge_switch_off
);

  localparam int NTMR = 10;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_ff;
  logic [31:0] oc_thr_ff;
  logic [31:0] oc_dly_ff;
  logic [31:0] l3_thr_ff;
  logic [31:0] latch_ff;
  logic [31:0] lrec_ff;
  logic [31:0] ot_thr_ff;
  logic [31:0] ot_dly_ff;
  logic [31:0] reg_rdata_ff;

  // Protection state
  logic [5:0] alert_ff;
  logic [5:0] fault_ff;
  logic dsg_alarm_ff;
  logic [7:0] latch_cnt_ff;
  logic load_meta_ff;
  logic load_sync_ff;

  // Timebase and timers
  logic [27:0] fast_cnt_ff;
  logic [27:0] slow_cnt_ff;
  logic fast_tick;
  logic slow_tick;
  logic [NTMR-1:0] tmr_cond;
  logic [NTMR-1:0] tmr_fast;
  logic [NTMR-1:0] tmr_done;
  logic [8:0] tmr_target [NTMR];

  // Derived conditions
  logic signed [7:0] max_temp;
  logic cond_l1;
  logic cond_l2;
  logic cond_l3;
  logic cond_otc;
  logic cond_otd;
  logic [2:0] oc_trip;
  logic oc_any_fault;
  logic oc_recover;
  logic latch_set;
  logic latch_reset;
  logic latch_cmd;
  logic auto_ctl;
  dcg_status_t status;

  assign auto_ctl = ctrl_ff[`DCG_CTRL_AUTO];

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------

  // Configuration writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= `DCG_RST_WORD;
      oc_thr_ff <= `DCG_RST_WORD;
      oc_dly_ff <= `DCG_RST_WORD;
      l3_thr_ff <= `DCG_RST_WORD;
      latch_ff <= `DCG_RST_WORD;
      lrec_ff <= `DCG_RST_WORD;
      ot_thr_ff <= `DCG_RST_WORD;
      ot_dly_ff <= `DCG_RST_WORD;
    end else if (reg_write) begin
      case (reg_addr)
        `DCG_OFF_CTRL: ctrl_ff <= reg_wdata;
        `DCG_OFF_OC_THR: oc_thr_ff <= reg_wdata;
        `DCG_OFF_OC_DLY: oc_dly_ff <= reg_wdata;
        `DCG_OFF_L3_THR: l3_thr_ff <= reg_wdata;
        `DCG_OFF_LATCH: latch_ff <= reg_wdata;
        `DCG_OFF_LREC: lrec_ff <= reg_wdata;
        `DCG_OFF_OT_THR: ot_thr_ff <= reg_wdata;
        `DCG_OFF_OT_DLY: ot_dly_ff <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Host latch recovery command
  assign latch_cmd = reg_write && (reg_addr == `DCG_OFF_CMD) &&
                     (reg_wdata[15:0] == `DCG_CMD_LATCH_REC); // [R12]

  // Status word assembly
  always_comb begin
    status = '0;
    status.alert = alert_ff;
    status.fault = fault_ff;
    status.dsg_alarm = dsg_alarm_ff;
    status.chg_off = charge_switch_off;
    status.latch_count = latch_cnt_ff;
  end

  // Read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_ff <= `DCG_RST_WORD;
    end else if (reg_read) begin
      case (reg_addr)
        `DCG_OFF_CTRL: reg_rdata_ff <= ctrl_ff;
        `DCG_OFF_OC_THR: reg_rdata_ff <= oc_thr_ff;
        `DCG_OFF_OC_DLY: reg_rdata_ff <= oc_dly_ff;
        `DCG_OFF_L3_THR: reg_rdata_ff <= l3_thr_ff;
        `DCG_OFF_LATCH: reg_rdata_ff <= latch_ff;
        `DCG_OFF_LREC: reg_rdata_ff <= lrec_ff;
        `DCG_OFF_OT_THR: reg_rdata_ff <= ot_thr_ff;
        `DCG_OFF_OT_DLY: reg_rdata_ff <= ot_dly_ff;
        `DCG_OFF_STATUS: reg_rdata_ff <= status;
        `DCG_OFF_TEMP: reg_rdata_ff <= {{24{max_temp[7]}}, max_temp};
        default: reg_rdata_ff <= `DCG_RST_WORD;
      endcase
    end else begin
      reg_rdata_ff <= `DCG_RST_WORD;
    end
  end

  assign reg_rdata = reg_rdata_ff;

  // ----------------------------------------------------------------
  // Inputs and timebase
  // ----------------------------------------------------------------

  // Load-detect flag synchroniser
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      load_meta_ff <= 1'b0;
      load_sync_ff <= 1'b0;
    end else begin
      load_meta_ff <= load_removed;
      load_sync_ff <= load_meta_ff;
    end
  end

  // 3.3 ms and 1 s tick generators
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fast_cnt_ff <= 28'h0000000;
      slow_cnt_ff <= 28'h0000000;
    end else begin
      fast_cnt_ff <= fast_tick ? 28'h0000000 : fast_cnt_ff + 28'h0000001;
      slow_cnt_ff <= slow_tick ? 28'h0000000 : slow_cnt_ff + 28'h0000001;
    end
  end

  assign fast_tick = (fast_cnt_ff == 28'(FAST_TICK_CYC - 1));
  assign slow_tick = (slow_cnt_ff == 28'(SLOW_TICK_CYC - 1));

  // Hottest enabled cell sensor
  always_comb begin
    max_temp = 8'sh80;
    for (int i = 0; i < NUM_TEMP; i++) begin
      if (cell_temp_enable[i] && (cell_temp[i] > max_temp)) begin
        max_temp = cell_temp[i]; // [R17]
      end
    end
  end

  // ----------------------------------------------------------------
  // Alert conditions
  // ----------------------------------------------------------------
  assign cond_l1 = ctrl_ff[`DCG_CTRL_EN_L1] &&
                   (sense_neg_minus_pos_mv > $signed(oc_thr_ff[15:0])); // [R1]
  assign cond_l2 = ctrl_ff[`DCG_CTRL_EN_L2] && // [R1]
                   (sense_neg_minus_pos_mv > $signed(oc_thr_ff[31:16]));
  assign cond_l3 = ctrl_ff[`DCG_CTRL_EN_L3] && // [R2]
                   (coulomb_counter_current <= $signed(l3_thr_ff[15:0]));
  assign cond_otc = ctrl_ff[`DCG_CTRL_EN_OTC] &&
                    (max_temp >= $signed(ot_thr_ff[7:0])); // [R13]
  assign cond_otd = ctrl_ff[`DCG_CTRL_EN_OTD] &&
                    (max_temp >= $signed(ot_thr_ff[23:16])); // [R18]

  assign oc_any_fault = |fault_ff[`DCG_P_L3:`DCG_P_L1];

  // Timer conditions, tick choice and targets
  always_comb begin
    tmr_fast = '0;
    tmr_fast[TMR_L1] = 1'b1; // [R22]
    tmr_fast[TMR_L2] = 1'b1; // [R22]
    tmr_cond[TMR_L1] = cond_l1 && !fault_ff[`DCG_P_L1];
    tmr_cond[TMR_L2] = cond_l2 && !fault_ff[`DCG_P_L2];
    tmr_cond[TMR_L3] = cond_l3 && !fault_ff[`DCG_P_L3];
    tmr_cond[TMR_OTC] = cond_otc && !fault_ff[`DCG_P_OTC];
    tmr_cond[TMR_OTD] = cond_otd && !fault_ff[`DCG_P_OTD];
    tmr_cond[TMR_OCREC] = oc_any_fault &&
      (coulomb_counter_current > $signed(l3_thr_ff[31:16])); // [R6]
    tmr_cond[TMR_LREC] = fault_ff[`DCG_P_LATCH] &&
      ctrl_ff[`DCG_CTRL_CUR_REC] && ctrl_ff[`DCG_CTRL_SERIES] &&
      charge_switch_on &&
      (coulomb_counter_current > $signed(lrec_ff[15:0])); // [R11] [R24]
    tmr_cond[TMR_OTCREC] = fault_ff[`DCG_P_OTC] &&
      (max_temp <= $signed(ot_thr_ff[15:8])); // [R16]
    tmr_cond[TMR_OTDREC] = fault_ff[`DCG_P_OTD] &&
      (max_temp <= $signed(ot_thr_ff[31:24])); // [R21]
    tmr_cond[TMR_DEC] = !cond_l1 && !cond_l2 && !cond_l3 &&
      !oc_any_fault && (latch_cnt_ff != 8'h00); // [R7]
    tmr_target[TMR_L1] = {1'b0, oc_dly_ff[7:0]} + `DCG_L12_DLY_ADD; // [R22]
    tmr_target[TMR_L2] = {1'b0, oc_dly_ff[15:8]} + `DCG_L12_DLY_ADD;
    tmr_target[TMR_L3] = {1'b0, oc_dly_ff[23:16]}; // [R23]
    tmr_target[TMR_OTC] = {1'b0, ot_dly_ff[7:0]}; // [R14]
    tmr_target[TMR_OTD] = {1'b0, ot_dly_ff[15:8]}; // [R19]
    tmr_target[TMR_OCREC] = {1'b0, lrec_ff[23:16]};
    tmr_target[TMR_LREC] = {1'b0, latch_ff[23:16]}; // [R24]
    tmr_target[TMR_OTCREC] = {1'b0, lrec_ff[23:16]};
    tmr_target[TMR_OTDREC] = {1'b0, lrec_ff[23:16]};
    tmr_target[TMR_DEC] = {1'b0, latch_ff[15:8]};
  end

  // ----------------------------------------------------------------
  // Persistence timers
  // ----------------------------------------------------------------
  for (genvar t = 0; t < NTMR; t++) begin : g_tmr
    logic [8:0] cnt_ff;

    // Count ticks while the condition holds, restart otherwise
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        cnt_ff <= 9'h000;
      end else if (!tmr_cond[t] || tmr_done[t]) begin
        cnt_ff <= 9'h000; // [R25]
      end else if ((tmr_fast[t] ? fast_tick : slow_tick) &&
                   (cnt_ff < tmr_target[t])) begin
        cnt_ff <= cnt_ff + 9'h001;
      end
    end

    assign tmr_done[t] = tmr_cond[t] && (cnt_ff >= tmr_target[t]);
  end

  // ----------------------------------------------------------------
  // Overcurrent levels and discharge alarm
  // ----------------------------------------------------------------
  assign oc_trip = tmr_done[TMR_L3:TMR_L1]; // [R3]
  assign oc_recover = tmr_done[TMR_OCREC];

  // Latch counter and latch fault
  assign latch_set = ctrl_ff[`DCG_CTRL_EN_LATCH] && !fault_ff[`DCG_P_LATCH]
                     && (latch_cnt_ff != 8'h00)
                     && (latch_cnt_ff >= latch_ff[7:0]); // [R9]
  assign latch_reset = fault_ff[`DCG_P_LATCH] &&
    (load_sync_ff || tmr_done[TMR_LREC] || latch_cmd); // [R10] [R11] [R12]

  // Alert flags, cleared on trip
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      alert_ff <= 6'h00;
    end else begin
      alert_ff[`DCG_P_L1] <= tmr_cond[TMR_L1] && !oc_trip[0]; // [R1] [R3]
      alert_ff[`DCG_P_L2] <= tmr_cond[TMR_L2] && !oc_trip[1]; // [R1] [R3]
      alert_ff[`DCG_P_L3] <= tmr_cond[TMR_L3] && !oc_trip[2]; // [R2] [R3]
      alert_ff[`DCG_P_LATCH] <= (latch_cnt_ff != 8'h00) &&
        !fault_ff[`DCG_P_LATCH] && !latch_set; // [R8] [R9]
      alert_ff[`DCG_P_OTC] <= tmr_cond[TMR_OTC] && !tmr_done[TMR_OTC]; // [R14]
      alert_ff[`DCG_P_OTD] <= tmr_cond[TMR_OTD] && !tmr_done[TMR_OTD]; // [R19]
    end
  end

  // Fault flags; a trip in a clearing cycle still sets
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_ff <= 6'h00;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (oc_trip[i]) begin
          fault_ff[i] <= 1'b1; // [R3]
        end else if (oc_recover) begin
          fault_ff[i] <= 1'b0; // [R6]
        end
      end
      if (latch_set) begin
        fault_ff[`DCG_P_LATCH] <= 1'b1; // [R9]
      end else if (latch_reset) begin
        fault_ff[`DCG_P_LATCH] <= 1'b0; // [R10] [R11] [R12]
      end
      if (tmr_done[TMR_OTC]) begin
        fault_ff[`DCG_P_OTC] <= 1'b1; // [R14]
      end else if (tmr_done[TMR_OTCREC]) begin
        fault_ff[`DCG_P_OTC] <= 1'b0; // [R16]
      end
      if (tmr_done[TMR_OTD]) begin
        fault_ff[`DCG_P_OTD] <= 1'b1; // [R19]
      end else if (tmr_done[TMR_OTDREC]) begin
        fault_ff[`DCG_P_OTD] <= 1'b0; // [R21]
      end
    end
  end

  // Saturating repeated-overcurrent counter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_cnt_ff <= 8'h00;
    end else if (latch_reset) begin
      latch_cnt_ff <= (|oc_trip) ? 8'h01 : 8'h00; // [R10] [R11] [R12]
    end else if (|oc_trip) begin
      if (latch_cnt_ff != 8'hFF) begin
        latch_cnt_ff <= latch_cnt_ff + 8'h01; // [R5] [R26]
      end
    end else if (tmr_done[TMR_DEC]) begin
      latch_cnt_ff <= latch_cnt_ff - 8'h01; // [R7] [R26]
    end
  end

  // Discharge-switch-off alarm bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dsg_alarm_ff <= 1'b0;
    end else if (auto_ctl && ((|oc_trip) || latch_set)) begin
      dsg_alarm_ff <= 1'b1; // [R4] [R9]
    end else if (oc_recover && !fault_ff[`DCG_P_LATCH]) begin
      dsg_alarm_ff <= 1'b0; // [R6]
    end else if (latch_reset && !oc_any_fault) begin
      dsg_alarm_ff <= 1'b0; // [R10] [R11] [R12]
    end
  end

  // Switch requests
  assign discharge_switch_off = dsg_alarm_ff || (fault_ff[`DCG_P_OTD] &&
    auto_ctl && ctrl_ff[`DCG_CTRL_SEL_OTD]); // [R20]
  assign charge_switch_off = fault_ff[`DCG_P_OTC] && auto_ctl &&
    ctrl_ff[`DCG_CTRL_SEL_OTC]; // [R15]

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking dcg_cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  l1_alert_clear_a: assert property ( // [R1]
    !cond_l1 |=> !alert_ff[`DCG_P_L1])
    else $error("level one alert set without its condition");

  l3_alert_clear_a: assert property ( // [R2]
    (coulomb_counter_current > $signed(l3_thr_ff[15:0])) |=>
      !alert_ff[`DCG_P_L3])
    else $error("level three alert set above threshold");

  trip_sets_fault_a: assert property ( // [R3]
    oc_trip[0] |=> fault_ff[`DCG_P_L1] && !alert_ff[`DCG_P_L1])
    else $error("level one trip did not set fault");

  trip_alarm_a: assert property ( // [R4]
    ((|oc_trip) && auto_ctl) |=> dsg_alarm_ff && discharge_switch_off)
    else $error("trip did not raise discharge alarm");

  latch_inc_a: assert property ( // [R5]
    ((|oc_trip) && !latch_reset && latch_cnt_ff != 8'hFF) |=>
      latch_cnt_ff == $past(latch_cnt_ff) + 8'h01)
    else $error("latch counter missed an increment");

  oc_recovery_a: assert property ( // [R6]
    (oc_recover && !(|oc_trip)) |=> fault_ff[`DCG_P_L3:`DCG_P_L1] == 3'b000)
    else $error("overcurrent recovery left a fault set");

  latch_fault_a: assert property ( // [R9]
    latch_set |=> fault_ff[`DCG_P_LATCH] && !alert_ff[`DCG_P_LATCH])
    else $error("latch limit did not set latch fault");

  latch_clear_a: assert property ( // [R12]
    (latch_cmd && fault_ff[`DCG_P_LATCH] && !(|oc_trip)) |=>
      !fault_ff[`DCG_P_LATCH] && latch_cnt_ff == 8'h00)
    else $error("host recovery did not clear latch");

  count_sat_a: assert property ( // [R26]
    (latch_cnt_ff == 8'hFF && (|oc_trip) && !latch_reset) |=>
      latch_cnt_ff == 8'hFF)
    else $error("latch counter left its maximum");

  otc_fault_a: assert property ( // [R14]
    tmr_done[TMR_OTC] |=> fault_ff[`DCG_P_OTC] ##1 fault_ff[`DCG_P_OTC])
    else $error("charge overtemperature fault not held");

endmodule // dcg_guard

// [dcg_guard_test.sv]
/*
  Self-checking bench for the discharge current and cell heat guard.
  Assumes dcg_guard with shortened tick parameters and its defines.
*/
`timescale 1ns/1ps
`include "dcg_defs.svh"

module dcg_guard_test;
  import dcg_pkg::*;

  // ----------------------------------------------------------------
  // Signals and instance
  // ----------------------------------------------------------------
  localparam int FAST_CYC = 4;
  localparam int SLOW_CYC = 10;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic signed [15:0] sense = 16'sh0000;
  logic signed [15:0] ccur = 16'sh0000;
  logic load_gone = 1'b0;
  logic chg_on = 1'b0;
  logic signed [7:0] temps [4] = '{8'sh14, 8'sh3C, 8'sh1E, 8'sh46};
  logic [3:0] temp_en = 4'h0;
  logic dsg_off;
  logic chg_off;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;

  dcg_guard #(.NUM_TEMP(4), .FAST_TICK_CYC(FAST_CYC),
    .SLOW_TICK_CYC(SLOW_CYC)) dcg_guard_inst (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .sense_neg_minus_pos_mv(sense),
    .coulomb_counter_current(ccur), .cell_temp(temps),
    .cell_temp_enable(temp_en), .load_removed(load_gone),
    .charge_switch_on(chg_on), .discharge_switch_off(dsg_off),
    .charge_switch_off(chg_off));

  // Clock of 4 ns period
  always #2 clk = ~clk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  // Called at a rising edge; data stand only in the cycle after the strobe
  task automatic rd(string name, logic [7:0] a, logic [31:0] exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    chk(name, exp, reg_rdata);
    @(posedge clk);
  endtask

  task automatic idle(int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic st(logic [31:0] exp);
    rd("status", `DCG_OFF_STATUS, exp);
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    idle(8);
    reset_n <= 1'b1;
    rd("ctrl", `DCG_OFF_CTRL, 32'h0000_0000);
    st(32'h0000_0000);
    rd("unmapped", 8'h3C, 32'h0000_0000);
    $display("test reset done");
    // Levels enabled, latch limit 2, long decrement delay
    wr(`DCG_OFF_OC_THR, 32'h7FFF_0032);
    wr(`DCG_OFF_OC_DLY, 32'h0000_0000);
    wr(`DCG_OFF_L3_THR, 32'h0064_FF9C);
    wr(`DCG_OFF_LATCH, 32'h0000_FF02);
    wr(`DCG_OFF_LREC, 32'h0001_0064);
    wr(`DCG_OFF_CTRL, 32'h0000_004F);
    sense <= 16'sh0032;
    idle(3);
    st(32'h0000_0000);
    sense <= 16'sh0033;
    idle(1);
    st(32'h0000_0001);
    idle(20);
    st(32'h0101_0108);
    chk("dsg_off", 32'h1, {31'h0, dsg_off});
    sense <= 16'sh0000;
    ccur <= 16'sh00C8;
    idle(30);
    st(32'h0100_0008);
    $display("test level one done");
    ccur <= -16'sh00C8;
    idle(5);
    st(32'h0201_0C00);
    wr(`DCG_OFF_CMD, 32'h0000_009B);
    idle(2);
    st(32'h0001_0400);
    chk("dsg_off", 32'h1, {31'h0, dsg_off});
    ccur <= 16'sh00C8;
    idle(30);
    st(32'h0000_0000);
    chk("dsg_off", 32'h0, {31'h0, dsg_off});
    $display("test latch done");
    ccur <= -16'sh00C8;
    idle(5);
    st(32'h0101_0408);
    ccur <= 16'sh00C8;
    idle(30);
    wr(`DCG_OFF_LATCH, 32'h0000_0102);
    idle(40);
    st(32'h0000_0000);
    $display("test decrement done");
    // Latch at limit one, then load removal and charge current resets
    wr(`DCG_OFF_LATCH, 32'h0000_FF01);
    ccur <= -16'sh00C8;
    idle(5);
    ccur <= 16'sh00C8;
    idle(30);
    st(32'h0101_0800);
    load_gone <= 1'b1;
    idle(5);
    st(32'h0000_0000);
    chk("dsg_off", 32'h0, {31'h0, dsg_off});
    load_gone <= 1'b0;
    ccur <= -16'sh00C8;
    idle(5);
    ccur <= 16'sh00C8;
    wr(`DCG_OFF_CTRL, 32'h0000_01CF);
    idle(30);
    st(32'h0101_0800);
    chg_on <= 1'b1;
    idle(3);
    st(32'h0000_0000);
    chg_on <= 1'b0;
    $display("test latch reset done");
    // Both heat checks with switch selection, max of enabled sensors
    wr(`DCG_OFF_OT_THR, 32'h323C_323C);
    wr(`DCG_OFF_OT_DLY, 32'h0000_0000);
    wr(`DCG_OFF_CTRL, 32'h0000_0670);
    temp_en <= 4'h7;
    idle(3);
    rd("temp", `DCG_OFF_TEMP, 32'h0000_003C);
    idle(3);
    st(32'h0002_3000);
    chk("chg_off", 32'h1, {31'h0, chg_off});
    chk("dsg_off", 32'h1, {31'h0, dsg_off});
    temp_en <= 4'h1;
    idle(30);
    rd("temp", `DCG_OFF_TEMP, 32'h0000_0014);
    st(32'h0000_0000);
    chk("chg_off", 32'h0, {31'h0, chg_off});
    chk("dsg_off", 32'h0, {31'h0, dsg_off});
    $display("test heat done");
    finish_test();
  end
endmodule // dcg_guard_test
